// File: serial_card_pkg.sv
// register map, field positions, reset values and shared types of the serial/smart card unit
// assumes a 32-bit Avalon-MM slave port with byte addresses, one register per aligned word
package serial_card_pkg;

  // register byte offsets
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_BAUD = 5'h04;
  localparam logic [4:0] OFF_TXBUF = 5'h08;
  localparam logic [4:0] OFF_RXBUF = 5'h0c;
  localparam logic [4:0] OFF_STAT = 5'h10;
  localparam logic [4:0] OFF_SCMODE = 5'h14;

  // control register fields
  localparam int CTRL_SMART = 0;
  localparam int CTRL_TXEN = 1;
  localparam int CTRL_RXEN = 2;
  localparam int CTRL_EXTCLK = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // status register fields
  localparam int STAT_TXEMPTY = 0;
  localparam int STAT_TXEND = 1;
  localparam int STAT_RXFULL = 2;
  localparam int STAT_OVERRUN = 3;
  localparam int STAT_PARITY = 4;
  localparam int STAT_RETRY = 5;

  // smart card mode register
  localparam int SCM_DIR = 3;
  localparam int SCM_INV = 2;
  localparam logic [7:0] SCMODE_RESET = 8'hf2;
  localparam logic [3:0] SCMODE_RO_ONES = 4'hf;

  localparam logic [7:0] BAUD_RESET = 8'h00;

  // bit timing
  localparam logic [3:0] SAMPLE_PHASE = 4'h7;
  localparam logic [3:0] LAST_PHASE = 4'hf;
  localparam logic [2:0] SCK_HALF_LAST = 3'h7;
  localparam logic [3:0] SYNC_LAST_BIT = 4'h7;
  localparam logic [3:0] SYNC_BITS = 4'h8;
  localparam logic [3:0] SC_PARITY_BIT = 4'h9;
  localparam logic [3:0] SC_ERR_BIT = 4'ha;
  localparam logic [3:0] SC_LAST_BIT = 4'hb;

  typedef struct packed {
    logic tx_empty;
    logic tx_end;
    logic rx_full;
    logic rx_err;
  } serial_req_t;

  typedef struct packed {
    logic tx;
    logic rx;
  } dma_req_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SHIFT = 3'b010,
    TX_GUARD = 3'b100
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_SHIFT = 3'b010,
    RX_SIGNAL = 3'b100
  } rx_state_t;

endpackage

// File: serial_card_unit.sv
// serial communication unit: clock-synchronous mode and smart card (asynchronous) mode
// assumes serial pins are synchronous to clk; the smart card line is open drain with a pull-up
// outside and txd and rxd joined on the card side
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module serial_card_unit #(
  parameter int unsigned BAUD_WIDTH = 8,
  parameter bit CHANNEL_ZERO = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // power state
  input wire logic standby,
  // serial pins
  input wire logic rxd,
  output logic txd_o,
  output logic txd_oe,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  // requests
  output serial_card_pkg::serial_req_t req,
  output serial_card_pkg::dma_req_t dma_req
);
  import serial_card_pkg::*;

  if (BAUD_WIDTH < 2 || BAUD_WIDTH > 16) begin : bad_baud_width
    $error("BAUD_WIDTH must lie between 2 and 16");
  end

  logic [7:0] ctrl_reg;
  logic [BAUD_WIDTH-1:0] baud_reg;
  logic [BAUD_WIDTH-1:0] baud_cnt_reg;
  logic [7:0] transmit_buffer_reg;
  logic [7:0] receive_buffer_reg;
  logic [3:0] smart_card_mode_reg;
  logic tx_empty_reg, rx_full_reg, overrun_reg, parity_err_reg, retry_err_reg;

  logic smart, tx_en, rx_en, ext_clk, msb_first, invert;
  assign smart = ctrl_reg[CTRL_SMART];
  assign tx_en = ctrl_reg[CTRL_TXEN];
  assign rx_en = ctrl_reg[CTRL_RXEN];
  assign ext_clk = ctrl_reg[CTRL_EXTCLK];
  assign msb_first = smart_card_mode_reg[SCM_DIR];
  assign invert = smart_card_mode_reg[SCM_INV];

  // bus access: one wait cycle, then the request is taken at the edge that sees waitrequest low
  logic taken, wr, rd;
  assign taken = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr = taken & avs_write & avs_byteenable[0];
  assign rd = taken & avs_read;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    end
  end

  logic [7:0] status;
  always_comb begin
    status = 8'h00;
    status[STAT_TXEMPTY] = tx_empty_reg;
    status[STAT_TXEND] = tx_end;
    status[STAT_RXFULL] = rx_full_reg;
    status[STAT_OVERRUN] = overrun_reg;
    status[STAT_PARITY] = parity_err_reg;
    status[STAT_RETRY] = retry_err_reg;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & avs_waitrequest) begin
      case (avs_address)
        OFF_CTRL: avs_readdata <= {24'h00_0000, ctrl_reg};
        OFF_BAUD: avs_readdata <= 32'(baud_reg);
        OFF_TXBUF: avs_readdata <= {24'h00_0000, transmit_buffer_reg};
        OFF_RXBUF: avs_readdata <= {24'h00_0000, receive_buffer_reg};
        OFF_STAT: avs_readdata <= {24'h00_0000, status};
        OFF_SCMODE: avs_readdata <= {24'h00_0000, SCMODE_RO_ONES, smart_card_mode_reg};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  logic wr_txbuf, rd_rxbuf, wr_stat;
  assign wr_txbuf = wr & (avs_address == OFF_TXBUF);
  assign rd_rxbuf = rd & (avs_address == OFF_RXBUF);
  assign wr_stat = wr & (avs_address == OFF_STAT);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_reg <= CTRL_RESET;
      baud_reg <= BAUD_WIDTH'(BAUD_RESET);
    end else if (wr && avs_address == OFF_CTRL) begin
      ctrl_reg <= avs_writedata[7:0];
    end else if (wr && avs_address == OFF_BAUD) begin
      baud_reg <= avs_writedata[BAUD_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || standby) begin
      smart_card_mode_reg <= SCMODE_RESET[3:0];
    end else if (wr && avs_address == OFF_SCMODE) begin
      smart_card_mode_reg <= avs_writedata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      transmit_buffer_reg <= 8'h00;
    end else if (wr_txbuf) begin
      transmit_buffer_reg <= avs_writedata[7:0];
    end
  end

  // baud generator: one tick per 1/16 bit
  logic tick16;
  assign tick16 = (baud_cnt_reg == baud_reg);
  always_ff @(posedge clk) begin
    if (sys_rst || tick16) begin
      baud_cnt_reg <= '0;
    end else begin
      baud_cnt_reg <= baud_cnt_reg + 1'b1;
    end
  end

  tx_state_t tx_state;
  rx_state_t rx_state;
  logic [7:0] tx_sr, tx_frame;
  logic [3:0] tx_bit, tx_ph, rx_bit, rx_ph;
  logic tx_err_seen;

  // synchronous serial clock: internal runs only while there is work, idle high
  logic sync_run, sck_prev, sck_cur, sck_rise, sck_fall;
  logic [2:0] sck_ph;
  assign sync_run = ~smart & ~ext_clk & ((tx_state != TX_IDLE) | (rx_en & ~tx_en));
  assign sck_cur = ext_clk ? sck_i : sck_o;
  assign sck_rise = sck_cur & ~sck_prev;
  assign sck_fall = ~sck_cur & sck_prev;

  always_ff @(posedge clk) begin
    if (sys_rst || !sync_run) begin
      sck_o <= 1'b1;
      sck_ph <= 3'h0;
    end else if (tick16) begin
      sck_ph <= sck_ph + 1'b1;
      if (sck_ph == SCK_HALF_LAST) begin
        sck_o <= ~sck_o;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sck_prev <= 1'b1;
      sck_oe <= 1'b0;
    end else begin
      sck_prev <= sck_cur;
      sck_oe <= ~smart & ~ext_clk; // far end drives the pin in external mode
    end
  end

  // transmitter
  logic tx_sync_last, tx_load, tx_end, tx_retry;
  logic tx_data_bit;
  assign tx_sync_last = ~smart & (tx_state == TX_SHIFT) & sck_rise & (tx_bit == SYNC_LAST_BIT);
  assign tx_load = tx_en & ~tx_empty_reg & ((tx_state == TX_IDLE) | tx_sync_last);
  assign tx_end = tx_empty_reg & (tx_state == TX_IDLE);
  assign tx_data_bit = (msb_first ? tx_sr[7] : tx_sr[0]) ^ invert;
  assign tx_retry = smart & (tx_state == TX_GUARD) & tick16 & (tx_ph == LAST_PHASE) &
                    (tx_bit == SC_LAST_BIT) & tx_err_seen;

  function automatic logic [7:0] shift_out(input logic [7:0] sr, input logic msb);
    shift_out = msb ? {sr[6:0], 1'b0} : {1'b0, sr[7:1]};
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic msb, input logic b);
    shift_in = msb ? {sr[6:0], b} : {b, sr[7:1]};
  endfunction

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_state <= TX_IDLE;
      tx_sr <= 8'h00;
      tx_frame <= 8'h00;
      tx_bit <= 4'h0;
      tx_ph <= 4'h0;
      tx_err_seen <= 1'b0;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if (tx_load) begin
            tx_sr <= transmit_buffer_reg;
            tx_frame <= transmit_buffer_reg;
            tx_bit <= 4'h0;
            tx_ph <= 4'h0;
            tx_err_seen <= 1'b0;
            tx_state <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (smart) begin
            if (tick16) begin
              tx_ph <= tx_ph + 1'b1;
              if (tx_ph == LAST_PHASE) begin
                tx_bit <= tx_bit + 1'b1;
                if (tx_bit != 4'h0 && tx_bit <= SYNC_BITS) begin
                  tx_sr <= shift_out(tx_sr, msb_first);
                end
                if (tx_bit == SC_PARITY_BIT) begin
                  tx_state <= TX_GUARD;
                end
              end
            end
          end else begin
            if (sck_fall && tx_bit != 4'h0) begin
              tx_sr <= shift_out(tx_sr, msb_first);
            end
            if (sck_rise) begin
              tx_bit <= tx_bit + 1'b1;
              if (tx_sync_last) begin
                tx_bit <= 4'h0;
                if (tx_load) begin
                  tx_sr <= transmit_buffer_reg; // gapless next character
                  tx_frame <= transmit_buffer_reg;
                end else begin
                  tx_state <= TX_IDLE;
                end
              end
            end
          end
        end
        TX_GUARD: begin
          if (tick16) begin
            tx_ph <= tx_ph + 1'b1;
            if (tx_ph == LAST_PHASE) begin
              tx_bit <= tx_bit + 1'b1;
              if (tx_bit == SC_ERR_BIT) begin
                tx_err_seen <= ~rxd; // card pulls the line low about 11 bits in
              end
              if (tx_bit == SC_LAST_BIT) begin
                tx_bit <= 4'h0;
                tx_err_seen <= 1'b0;
                if (tx_err_seen) begin
                  tx_sr <= tx_frame;
                  tx_state <= TX_SHIFT;
                end else begin
                  tx_state <= TX_IDLE;
                end
              end
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // receiver
  logic rx_din, rx_sample, rx_done, rx_perr, rx_par, rx_err_drive;
  logic [7:0] rx_sr, rx_word;
  assign rx_din = rxd ^ invert;
  assign rx_sample = tick16 & (rx_ph == SAMPLE_PHASE);
  assign rx_done = (rx_state == RX_SHIFT) &
                   (smart ? (rx_sample & (rx_bit == SC_PARITY_BIT))
                          : (sck_rise & (rx_bit == SYNC_LAST_BIT)));
  assign rx_perr = smart & (rx_par ^ rxd);
  assign rx_word = smart ? rx_sr : shift_in(rx_sr, msb_first, rx_din);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_state <= RX_IDLE;
      rx_sr <= 8'h00;
      rx_bit <= 4'h0;
      rx_ph <= 4'h0;
      rx_par <= 1'b0;
      rx_err_drive <= 1'b0;
    end else begin
      case (rx_state)
        RX_IDLE: begin
          rx_bit <= 4'h0;
          rx_ph <= 4'h0;
          rx_par <= 1'b0;
          rx_err_drive <= 1'b0;
          if (rx_en && (!smart || (tick16 && !rxd))) begin
            rx_state <= RX_SHIFT;
          end
        end
        RX_SHIFT: begin
          if (!rx_en) begin
            rx_state <= RX_IDLE;
          end else if (smart) begin
            if (tick16) begin
              rx_ph <= rx_ph + 1'b1;
            end
            if (rx_sample) begin
              if (rx_bit == 4'h0 && rxd) begin
                rx_state <= RX_IDLE; // glitch, not a start bit
              end else if (rx_bit != 4'h0 && rx_bit <= SYNC_BITS) begin
                rx_sr <= shift_in(rx_sr, msb_first, rx_din);
                rx_par <= rx_par ^ rxd;
              end else if (rx_bit == SC_PARITY_BIT) begin
                rx_par <= rx_perr;
              end
            end
            if (tick16 && rx_ph == LAST_PHASE) begin
              rx_bit <= rx_bit + 1'b1;
              if (rx_bit == SC_PARITY_BIT) begin
                rx_state <= RX_SIGNAL;
              end
            end
          end else if (sck_rise) begin
            rx_sr <= rx_word;
            rx_bit <= (rx_bit == SYNC_LAST_BIT) ? 4'h0 : rx_bit + 1'b1;
          end
        end
        RX_SIGNAL: begin
          if (tick16) begin
            rx_ph <= rx_ph + 1'b1;
            if (rx_ph == SAMPLE_PHASE) begin
              rx_err_drive <= (rx_bit == SC_ERR_BIT) & rx_par;
            end
            if (rx_ph == LAST_PHASE) begin
              rx_bit <= rx_bit + 1'b1;
              if (rx_bit == SC_LAST_BIT) begin
                rx_state <= RX_IDLE; // 12-bit frame incl. guard time
              end
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // line driver: push-pull in synchronous mode, pull-low only in smart card mode
  logic sc_low;
  always_comb begin
    sc_low = 1'b0;
    if (tx_state == TX_SHIFT) begin
      if (tx_bit == 4'h0) begin
        sc_low = 1'b1;
      end else if (tx_bit == SC_PARITY_BIT) begin
        sc_low = ~(^tx_frame);
      end else begin
        sc_low = ~tx_data_bit;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txd_o <= 1'b1;
      txd_oe <= 1'b0;
    end else if (smart) begin
      txd_o <= 1'b0;
      txd_oe <= sc_low | rx_err_drive;
    end else begin
      txd_o <= (tx_state == TX_SHIFT) ? tx_data_bit : 1'b1;
      txd_oe <= tx_en;
    end
  end

  // buffer flags; hardware sets win over software clears, but a transmit buffer write wins over the tx_load that sets tx_empty
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_empty_reg <= 1'b1;
    end else if (wr_txbuf) begin
      tx_empty_reg <= 1'b0;
    end else if (tx_load) begin
      tx_empty_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      receive_buffer_reg <= 8'h00;
      rx_full_reg <= 1'b0;
    end else if (rx_done && (!rx_full_reg || rd_rxbuf)) begin
      receive_buffer_reg <= rx_word;
      rx_full_reg <= 1'b1;
    end else if (rx_done) begin
      rx_full_reg <= 1'b1;
    end else if (rd_rxbuf) begin
      rx_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      overrun_reg <= 1'b0;
      parity_err_reg <= 1'b0;
      retry_err_reg <= 1'b0;
    end else begin
      if (rx_done && rx_full_reg && !rd_rxbuf) begin
        overrun_reg <= 1'b1;
      end else if (wr_stat && avs_writedata[STAT_OVERRUN]) begin
        overrun_reg <= 1'b0;
      end
      if (rx_done && rx_perr) begin
        parity_err_reg <= 1'b1;
      end else if (wr_stat && avs_writedata[STAT_PARITY]) begin
        parity_err_reg <= 1'b0;
      end
      if (tx_retry) begin
        retry_err_reg <= 1'b1;
      end else if (wr_stat && avs_writedata[STAT_RETRY]) begin
        retry_err_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req <= '0;
      dma_req <= '0;
    end else begin
      req.tx_empty <= tx_en & tx_empty_reg;
      req.tx_end <= ~smart & tx_en & tx_end;
      req.rx_full <= rx_full_reg;
      req.rx_err <= overrun_reg | (smart & (parity_err_reg | retry_err_reg));
      dma_req.tx <= (CHANNEL_ZERO | smart) & tx_en & tx_empty_reg;
      dma_req.rx <= (CHANNEL_ZERO | smart) & rx_full_reg;
    end
  end

endmodule

// File: serial_card_unit_chk.sv
// port-level checks of the serial/smart card unit
// assumes one clk domain with synchronous active-high sys_rst; attached by the bind below
`timescale 1ns/1ps
module serial_card_unit_chk
  import serial_card_pkg::*;
#(
  parameter bit CHANNEL_ZERO = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // pins and requests
  input wire logic txd_o,
  input wire logic txd_oe,
  input wire serial_card_pkg::serial_req_t req,
  input wire serial_card_pkg::dma_req_t dma_req
);
  import serial_card_pkg::*;
  logic smart_reg;
  wire rd_taken = avs_read && !avs_waitrequest;
  // mode is tracked from taken writes, so the mode bit needs no extra port
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      smart_reg <= 1'b0;
    end else if (avs_write && !avs_waitrequest && avs_address == OFF_CTRL && avs_byteenable[0]) begin
      smart_reg <= avs_writedata[CTRL_SMART];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_req_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_ack_one;
    s_req_wait |=> s_ack;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("acknowledge not one cycle");
  property p_ack_cause;
    $fell(avs_waitrequest) |-> $past(avs_read || avs_write);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("acknowledge without request");
  property p_scm_ro;
    rd_taken && avs_address == OFF_SCMODE |-> avs_readdata[7:4] == SCMODE_RO_ONES && avs_readdata[31:8] == 24'h0;
  endproperty
  a_scm_ro: assert property (p_scm_ro) else $error("mode register upper bits wrong");
  property p_unmapped;
    rd_taken && avs_address[4:2] > 3'h5 |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_reset_outs;
    disable iff (1'b0) sys_rst |=> avs_waitrequest && !txd_oe && req == 4'h0 && dma_req == 2'h0;
  endproperty
  a_reset_outs: assert property (p_reset_outs) else $error("outputs wrong in reset");
  property p_dma;
    dma_req == (CHANNEL_ZERO ? {req.tx_empty, req.rx_full} : 2'h0);
  endproperty
  a_dma: assert property (p_dma) else $error("dma trigger differs from request");
  property p_open_drain;
    smart_reg && $past(smart_reg, 2) && txd_oe |-> !txd_o;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("card line driven high");
  // the flag clears at the taken edge and the request register follows one clock later
  property p_rx_clear;
    rd_taken && avs_address == OFF_RXBUF |-> ##2 !req.rx_full;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("receive full not cleared");
endmodule
bind serial_card_unit serial_card_unit_chk #(.CHANNEL_ZERO(CHANNEL_ZERO)) chk (
  .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .txd_o(txd_o),
  .txd_oe(txd_oe), .req(req), .dma_req(dma_req)
);

// File: card_peer.sv
// far side of the serial pins: a synchronous peer and a smart card on one joined line
// assumes the device's own sck in sync mode and 16 clocks per bit in smart card mode
`timescale 1ns/1ps
module card_peer (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench control
  input wire logic smart,
  input wire logic [7:0] tx_byte,
  input wire logic nack,
  input wire logic send,
  input wire logic bad,
  // device pins
  input wire logic txd_o,
  input wire logic txd_oe,
  input wire logic sck_o,
  input wire logic sck_oe,
  output logic rxd,
  // observations
  output logic [7:0] got,
  output logic got_stb,
  output logic busy,
  output logic err
);
  logic [2:0] cnt_reg, sel_reg;
  logic [7:0] sh_reg, t_reg;
  logic [9:0] fr_reg;
  logic sck_d, card_low, nack_l, tx_mode;
  // pull-up on the line; the card only ever pulls it low, the device pulls it low in smart card mode but drives it push-pull in sync mode
  wire line = (txd_oe ? txd_o : 1'b1) & !card_low;
  wire sck_line = sck_oe ? sck_o : 1'b1;
  assign rxd = smart ? line : tx_byte[sel_reg];
  always_ff @(posedge clk) begin
    sck_d <= sck_line;
    got_stb <= 1'b0;
    if (rst) begin
      cnt_reg <= 3'h0;
      sel_reg <= 3'h0;
      busy <= 1'b0;
      card_low <= 1'b0;
      err <= 1'b0;
    end else if (!smart) begin
      if (sck_line && !sck_d) begin
        sh_reg <= {line, sh_reg[7:1]};
        cnt_reg <= cnt_reg + 3'h1;
        got <= {line, sh_reg[7:1]};
        got_stb <= cnt_reg == 3'h7;
      end else if (!sck_line && sck_d) begin
        sel_reg <= cnt_reg;
      end
    end else if (!busy) begin
      t_reg <= 8'h0;
      tx_mode <= send;
      busy <= send || !line;
      nack_l <= nack;
      card_low <= send;
      fr_reg <= {(^tx_byte) ^ bad, tx_byte, 1'b0};
      if (send) begin
        err <= 1'b0;
      end
    end else if (tx_mode) begin
      t_reg <= t_reg + 8'h1;
      card_low <= t_reg < 8'd159 && !fr_reg[(t_reg + 8'h1) >> 4];
      if (t_reg == 8'd176) begin
        err <= !line;
      end
      if (t_reg == 8'd199) begin
        busy <= 1'b0;
      end
    end else begin
      t_reg <= t_reg + 8'h1;
      if (t_reg[3:0] == 4'h8 && t_reg[7:4] >= 4'h1 && t_reg[7:4] <= 4'h9) begin
        fr_reg <= {line, fr_reg[9:1]};
      end
      if (t_reg == 8'd160) begin
        got <= fr_reg[8:1];
        got_stb <= 1'b1;
        nack_l <= nack_l || ^fr_reg[9:1];
      end
      if (t_reg == 8'd168) begin
        card_low <= nack_l;
      end
      if (t_reg == 8'd184) begin
        card_low <= 1'b0;
      end
      if (t_reg == 8'd189) begin
        busy <= 1'b0;
      end
    end
  end
endmodule

// File: serial_card_unit_tb.sv
// self-checking bench: registers, sync transfers with a peer, smart card frames
// assumes card_peer on the serial pins; results are checked from queues of expectations
`timescale 1ns/1ps
module serial_card_unit_tb;
  import serial_card_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] avs_address = 5'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, rxd, txd_o, txd_oe, sck_o, sck_oe, got_stb, busy, err;
  logic standby = 1'b0, smart = 1'b0, nack = 1'b0, send = 1'b0, bad = 1'b0;
  logic [7:0] tx_byte = 8'h0, got;
  serial_req_t req;
  dma_req_t dma_req;
  logic [63:0] rd_q[$];
  logic [7:0] peer_q[$];
  int miscompares = 0, check_count = 0;
  logic [15:0] rnd = 16'd34971;
  always #2.5 clk = ~clk;
  serial_card_unit dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .standby(standby), .rxd(rxd), .txd_o(txd_o), .txd_oe(txd_oe), .sck_i(1'b1),
    .sck_o(sck_o), .sck_oe(sck_oe), .req(req), .dma_req(dma_req));
  card_peer peer (.clk(clk), .rst(sys_rst), .smart(smart), .tx_byte(tx_byte), .nack(nack),
    .send(send), .bad(bad), .txd_o(txd_o), .txd_oe(txd_oe), .sck_o(sck_o), .sck_oe(sck_oe),
    .rxd(rxd), .got(got), .got_stb(got_stb), .busy(busy), .err(err));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [7:0] xs();
    rnd ^= rnd << 7;
    rnd ^= rnd >> 9;
    rnd ^= rnd << 8;
    return rnd[7:0];
  endfunction
  function automatic logic [7:0] rev(input logic [7:0] b);
    for (int i = 0; i < 8; i++) rev[i] = b[7 - i];
  endfunction
  // every request waits for waitrequest low; no latency is assumed
  task automatic bus(input logic [4:0] a, input logic wr, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n == 50) check("bus wait", a, 32'hffff);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] mask, input logic [31:0] exp);
    rd_q.push_back({mask, exp});
    bus(a, 1'b0, 8'h0);
  endtask
  function automatic logic cond(input int w);
    case (w)
      0: return req.tx_empty;
      1: return req.tx_end;
      2: return !busy;
      3: return peer_q.size() < 2;
      default: return peer_q.size() == 0;
    endcase
  endfunction
  task automatic wait_for(input int w);
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    while (cond(w) !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (n == 4000) check("wait", w, 32'hffff);
  endtask
  // a missing expectation compares against unknown and so always counts
  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      check("read data", avs_readdata & rd_q[0][63:32], rd_q.size() ? rd_q[0][31:0] : 'x);
      void'(rd_q.pop_front());
    end
    if (got_stb === 1'b1) begin
      check("peer byte", got, peer_q.size() ? peer_q.pop_front() : 8'hxx);
    end
  end
  initial begin
    #250000;
    miscompares++;
    give_verdict();
  end
  initial begin
    int i;
    logic [7:0] b, p;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(OFF_CTRL, 32'hffffffff, {24'h0, CTRL_RESET});
    rd(OFF_SCMODE, 32'hffffffff, 32'hf2);
    rd(5'h18, 32'hffffffff, 32'h0);
    bus(OFF_SCMODE, 1'b1, 8'h00);
    rd(OFF_SCMODE, 32'hff, 32'hf0);
    bus(OFF_SCMODE, 1'b1, 8'h0f);
    rd(OFF_SCMODE, 32'hff, 32'hff);
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    rd(OFF_SCMODE, 32'hff, 32'hf2);
    bus(OFF_BAUD, 1'b1, 8'h01);
    rd(OFF_BAUD, 32'hff, 32'h01);
    bus(OFF_SCMODE, 1'b1, 8'h00);
    bus(OFF_CTRL, 1'b1, 8'h02);
    for (i = 0; i < 4; i++) begin
      b = xs();
      if (i == 3) begin
        wait_for(4);
        bus(OFF_SCMODE, 1'b1, 8'h0c);
      end
      peer_q.push_back(i == 3 ? ~rev(b) : b);
      wait_for(0);
      bus(OFF_TXBUF, 1'b1, b);
    end
    wait_for(4);
    wait_for(1);
    rd(OFF_STAT, 32'h3, 32'h3);
    bus(OFF_SCMODE, 1'b1, 8'h00);
    p = xs();
    tx_byte <= p;
    bus(OFF_CTRL, 1'b1, 8'h06);
    for (i = 0; i < 2; i++) begin
      b = xs();
      peer_q.push_back(b);
      wait_for(0);
      bus(OFF_TXBUF, 1'b1, b);
    end
    wait_for(4);
    wait_for(1);
    rd(OFF_STAT, 32'h0c, 32'h0c);
    check("rx error request", req.rx_err, 1'b1);
    rd(OFF_RXBUF, 32'hff, {24'h0, p});
    bus(OFF_STAT, 1'b1, 8'h08);
    rd(OFF_STAT, 32'h0c, 32'h0);
    bus(OFF_BAUD, 1'b1, 8'h00);
    smart <= 1'b1;
    bus(OFF_CTRL, 1'b1, 8'h03);
    for (i = 0; i < 2; i++) begin
      b = xs();
      bus(OFF_SCMODE, 1'b1, i ? 8'h0c : 8'h00);
      nack <= 1'b1;
      peer_q.push_back(i ? ~rev(b) : b);
      peer_q.push_back(i ? ~rev(b) : b);
      bus(OFF_TXBUF, 1'b1, b);
      wait_for(3);
      nack <= 1'b0;
      wait_for(4);
      wait_for(2);
      rd(OFF_STAT, 32'h20, 32'h20);
      check("card error request", req.rx_err, 1'b1);
      bus(OFF_STAT, 1'b1, 8'h20);
    end
    bus(OFF_CTRL, 1'b1, 8'h07);
    bus(OFF_SCMODE, 1'b1, 8'h00);
    for (i = 0; i < 2; i++) begin
      b = xs();
      tx_byte <= b;
      bad <= !i;
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      wait_for(2);
      check("error signal", err, !i);
      rd(OFF_STAT, 32'h14, i ? 32'h04 : 32'h14);
      rd(OFF_RXBUF, 32'hff, {24'h0, b});
      bus(OFF_STAT, 1'b1, 8'h10);
    end
    give_verdict();
  end
endmodule
